// file: rtl/mst_pkg.sv
// shared constants of the micro-step translator
package mst_pkg;
	localparam int POS_W  = 7;
	localparam int MODE_W = 3;
	localparam int CUR_W  = 5;
	localparam int COIL_W = 11;

	// register byte offsets, low address bits only
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_CUR    = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_COIL   = 12'h00C;

	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DIR_BIT  = 3;
	localparam int CTRL_POL_BIT  = 4;
	localparam int STAT_MODE_LSB = 8;
	localparam int STAT_CUR_LSB  = 16;
	localparam int COIL_Y_LSB    = 16;

	// reset values
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
	localparam logic [CUR_W-1:0]  CUR_RST  = 5'h00;
	localparam logic              DIR_RST  = 1'b0;
	localparam logic              POL_RST  = 1'b0;

	// step modes: 0 = 1/32 ... 4 = 1/2, 5 and above = full step
	localparam logic [MODE_W-1:0] MODE_FULL = 3'h5;
	localparam logic [POS_W-1:0]  POS_ONE   = 7'h01;
	localparam logic [5:0]        QUARTER   = 6'h20;

	// quarter-wave magnitudes in 0.1 percent of the peak current
	localparam logic [COIL_W-1:0] QTAB [0:32] = '{
		11'h000, 11'h023, 11'h051, 11'h07F, 11'h0AE, 11'h0DD, 11'h10B,
		11'h13A, 11'h15D, 11'h17F, 11'h1AE, 11'h1D1, 11'h1F4, 11'h222,
		11'h245, 11'h268, 11'h28B, 11'h2AE, 11'h2D1, 11'h2F3, 11'h316,
		11'h33A, 11'h351, 11'h368, 11'h37F, 11'h396, 11'h3A2, 11'h3AD,
		11'h3B9, 11'h3C5, 11'h3D1, 11'h3DC, 11'h3E8};
endpackage

// file: rtl/mst_step_cond.sv
// pin synchroniser and active-edge detector for the step and direction pins
`timescale 1ns/1ps
module mst_step_cond
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic step_pulse_in,
	input wire logic dir_in,
	mst_step_if.cond sif
);
	import mst_pkg::*;

	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic d1;
		logic d2;
	} mst_cond_s;

	mst_cond_s st_r;
	mst_cond_s st_nxt;
	logic      rise;
	logic      fall;

	// two flops per pin; s3 only serves the edge compare
	always_comb
	begin
		st_nxt    = st_r;
		st_nxt.s1 = step_pulse_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.d1 = dir_in;
		st_nxt.d2 = st_r.d1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// direction is taken from the same pipeline depth as the step edge
	assign rise         = st_r.s2 & ~st_r.s3;
	assign fall         = ~st_r.s2 & st_r.s3;
	assign sif.step_evt = sif.edge_pol ? fall : rise;
	assign sif.step_up  = st_r.d2 ^ sif.dir_ctrl;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_EDGE_POL: assert property (
		sif.step_evt |-> (st_r.s2 == !sif.edge_pol) && $changed(st_r.s2))
		else $error("step event on the wrong edge");
	AST_DIR_MIX: assert property (
		sif.step_evt && $stable(st_r.d1) |-> sif.step_up == ($past(dir_in, 2) ^ sif.dir_ctrl))
		else $error("direction not pin xor control bit");
endmodule // mst_step_cond

// file: rtl/mst_step_if.sv
// conditioned step event and direction between the pin stage and the translator
`timescale 1ns/1ps
interface mst_step_if;
	logic step_evt;
	logic step_up;
	logic edge_pol;
	logic dir_ctrl;

	modport cond
	(
		output step_evt,
		output step_up,
		input  edge_pol,
		input  dir_ctrl
	);
	modport xlat
	(
		input  step_evt,
		input  step_up,
		output edge_pol,
		output dir_ctrl
	);
endinterface

// file: rtl/mst_translator.sv
// micro-step translator: position counter, coil setpoints, peak current, AHB-Lite registers
// How it works
// - every active step edge moves position one step, drivers enabled or not
// - polarity bit picks rising or falling step edge
// - direction is the direction pin combined with the control bit
// - position is read as seven bits in 1/32 units, any mode
// - position read shows the new value right after a step
// - new step mode takes effect only at the next step edge
// - on finer mode, next step snaps to the nearest fine-grid point, then moves one fine step
// - coarser mode on a shared point keeps stepping on the table grid
// - coarser mode off the grid keeps the offset, coarse increments
// - new peak-current code applies at the next PWM period start
// - position maps to tabulated coil X and Y percentages
`timescale 1ns/1ps
module mst_translator
(
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         step_pulse_in,
	input  wire logic                         dir_in,
	input  wire logic                         pwm_period_start,
	output logic signed [mst_pkg::COIL_W-1:0] coil_x_setpoint,
	output logic signed [mst_pkg::COIL_W-1:0] coil_y_setpoint,
	output logic        [mst_pkg::CUR_W-1:0]  coil_peak_current,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata
);
	import mst_pkg::*;

	// every register of the block in one packed record
	typedef struct packed
	{
		logic [MODE_W-1:0] mode_set;
		logic [MODE_W-1:0] mode_app;
		logic              dir_ctrl;
		logic              edge_pol;
		logic [CUR_W-1:0]  cur_set;
		logic [CUR_W-1:0]  cur_app;
		logic [POS_W-1:0]  pos;
		logic [COIL_W-1:0] coil_x;
		logic [COIL_W-1:0] coil_y;
		logic              wr_pend;
		logic [11:0]       wr_addr;
		logic [31:0]       rdata;
	} mst_top_s;

	mst_top_s          st_r;
	mst_top_s          st_nxt;
	mst_step_if        sif();
	// step-path and bus helpers, all combinational
	logic              bus_take;
	logic              finer;
	logic [POS_W-1:0]  step_size;
	logic [POS_W-1:0]  grid_mask;
	logic [POS_W-1:0]  base_pos;
	logic [POS_W-1:0]  moved_pos;
	logic [2*COIL_W-1:0] coil_pair;

	// pin synchronisers and edge selection
	mst_step_cond u_cond
	(
		.clk           (clk),
		.rst_n         (rst_n),
		.step_pulse_in (step_pulse_in),
		.dir_in        (dir_in),
		.sif           (sif)
	);

	// settings handed to the pin stage
	assign sif.edge_pol = st_r.edge_pol;
	assign sif.dir_ctrl = st_r.dir_ctrl;

	// coil percentages from the quarter-wave table, sign by quadrant
	function automatic logic [2*COIL_W-1:0] coil_of(input logic [POS_W-1:0] p);
		logic [COIL_W-1:0] a;
		logic [COIL_W-1:0] b;
		a = QTAB[p[4:0]];
		b = QTAB[6'(QUARTER - {1'b0, p[4:0]})];
		case (p[6:5])
			2'h0:    coil_of = {a, b};
			2'h1:    coil_of = {b, COIL_W'(-a)};
			2'h2:    coil_of = {COIL_W'(-a), COIL_W'(-b)};
			default: coil_of = {COIL_W'(-b), a};
		endcase
	endfunction

	// step size of the mode being armed; anything past 1/2 is a full step
	always_comb
	begin
		if (st_r.mode_set >= MODE_FULL)
			step_size = POS_ONE << MODE_FULL;
		else
			step_size = POS_ONE << st_r.mode_set;
	end

	// smaller mode code means finer resolution
	assign finer     = st_r.mode_set < st_r.mode_app;
	assign grid_mask = step_size - POS_ONE;

	// finer: snap to nearest fine point first; otherwise keep any offset
	always_comb
	begin
		if (finer)
			base_pos = (st_r.pos + (step_size >> 1)) & ~grid_mask;
		else
			base_pos = st_r.pos;
	end

	// seven-bit sum wraps modulo 128 on its own
	assign moved_pos = sif.step_up ? base_pos + step_size : base_pos - step_size;

	// address phase accepted only once the previous transfer has ended
	assign bus_take  = hsel & htrans[1] & hready;

	// one process for translator, peak current and register file
	always_comb
	begin
		st_nxt         = st_r;
		st_nxt.wr_pend = 1'b0;
		// a step is taken whatever the driver state, no enable gates it
		if (sif.step_evt)
		begin
			st_nxt.pos      = moved_pos;
			st_nxt.mode_app = st_r.mode_set;
		end
		// amplitude changes only at a PWM period boundary
		if (pwm_period_start)
			st_nxt.cur_app = st_r.cur_set;
		// write data phase
		if (st_r.wr_pend)
		begin
			case (st_r.wr_addr)
				ADDR_CTRL:
				begin
					st_nxt.mode_set = hwdata[CTRL_MODE_LSB +: MODE_W];
					st_nxt.dir_ctrl = hwdata[CTRL_DIR_BIT];
					st_nxt.edge_pol = hwdata[CTRL_POL_BIT];
				end
				ADDR_CUR:
					st_nxt.cur_set = hwdata[CUR_W-1:0];
				default:
					st_nxt.wr_pend = 1'b0;
			endcase
		end
		// setpoints follow the position of this very cycle
		coil_pair     = coil_of(st_nxt.pos);
		st_nxt.coil_x = coil_pair[2*COIL_W-1:COIL_W];
		st_nxt.coil_y = coil_pair[COIL_W-1:0];
		// address phase; read data built from next values so a write just ahead is seen
		if (bus_take)
		begin
			st_nxt.wr_pend = hwrite;
			st_nxt.wr_addr = haddr[11:0];
			st_nxt.rdata   = 32'h0000_0000;
			if (!hwrite)
			begin
				case (haddr[11:0])
					ADDR_CTRL:
					begin
						st_nxt.rdata[CTRL_MODE_LSB +: MODE_W] = st_nxt.mode_set;
						st_nxt.rdata[CTRL_DIR_BIT]            = st_nxt.dir_ctrl;
						st_nxt.rdata[CTRL_POL_BIT]            = st_nxt.edge_pol;
					end
					ADDR_CUR:
						st_nxt.rdata[CUR_W-1:0] = st_nxt.cur_set;
					ADDR_STATUS:
					begin
						st_nxt.rdata[POS_W-1:0]              = st_nxt.pos;
						st_nxt.rdata[STAT_MODE_LSB +: MODE_W] = st_nxt.mode_app;
						st_nxt.rdata[STAT_CUR_LSB +: CUR_W]   = st_nxt.cur_app;
					end
					ADDR_COIL:
					begin
						st_nxt.rdata[COIL_W-1:0]             = st_nxt.coil_x;
						st_nxt.rdata[COIL_Y_LSB +: COIL_W]    = st_nxt.coil_y;
					end
					default:
						st_nxt.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// position resets to table entry zero, so setpoints reset to match it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r          <= '0;
			st_r.mode_set <= MODE_RST;
			st_r.mode_app <= MODE_RST;
			st_r.dir_ctrl <= DIR_RST;
			st_r.edge_pol <= POL_RST;
			st_r.cur_set  <= CUR_RST;
			st_r.cur_app  <= CUR_RST;
			st_r.coil_y   <= QTAB[QUARTER];
		end
		else
			st_r <= st_nxt;
	end

	// zero-wait slave, always OKAY
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign hrdata            = st_r.rdata;
	assign coil_x_setpoint   = st_r.coil_x;
	assign coil_y_setpoint   = st_r.coil_y;
	assign coil_peak_current = st_r.cur_app;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// step size, grid and wrap
	AST_STEP_MOVE: assert property (
		sif.step_evt && !finer |=> st_r.pos == $past(moved_pos)
		&& st_r.pos != $past(st_r.pos))
		else $error("step edge did not move the position");

	AST_STEP_SIZE: assert property (
		sif.step_evt && !finer |=> ($past(sif.step_up)
		? (st_r.pos - $past(st_r.pos)) == $past(step_size)
		: ($past(st_r.pos) - st_r.pos) == $past(step_size)))
		else $error("step was not one step of the armed size");

	AST_NO_STEP: assert property (
		!sif.step_evt |=> $stable(st_r.pos) && $stable(st_r.mode_app))
		else $error("position or mode moved without a step");

	AST_MODE_AT_STEP: assert property (
		sif.step_evt |=> st_r.mode_app == $past(st_r.mode_set))
		else $error("armed step mode not applied at step");

	AST_FINE_GRID: assert property (
		sif.step_evt && finer |=> (st_r.pos & $past(grid_mask)) == 7'h00)
		else $error("finer step left the fine grid");

	AST_SHARED_GRID: assert property (
		sif.step_evt && !finer && (st_r.pos & grid_mask) == 7'h00
		|=> (st_r.pos & $past(grid_mask)) == 7'h00)
		else $error("shared-point step left the table grid");

	AST_KEEP_OFFSET: assert property (
		sif.step_evt && !finer |=> (st_r.pos & $past(grid_mask))
		== ($past(st_r.pos) & $past(grid_mask)))
		else $error("coarse step lost its offset");

	AST_WRAP_UP: assert property (
		sif.step_evt && sif.step_up && !finer && st_r.pos == 7'h7F
		&& step_size == POS_ONE |=> st_r.pos == 7'h00)
		else $error("position did not wrap upward");

	AST_WRAP_DOWN: assert property (
		sif.step_evt && !sif.step_up && !finer && st_r.pos == 7'h00
		&& step_size == POS_ONE |=> st_r.pos == 7'h7F)
		else $error("position did not wrap downward");

	// peak current only moves at a period boundary
	AST_PEAK_APPLY: assert property (
		pwm_period_start |=> coil_peak_current == $past(st_r.cur_set))
		else $error("peak current not applied at period start");

	AST_PEAK_HOLD: assert property (
		!pwm_period_start |=> $stable(coil_peak_current))
		else $error("peak current changed mid period");

	// table points; setpoints must move together with the position
	AST_TABLE_96: assert property (
		st_r.pos == 7'h60 |-> coil_x_setpoint == -11'sh3E8 && coil_y_setpoint == 11'sh000)
		else $error("wrong setpoints at position 96");

	AST_TABLE_112: assert property (
		st_r.pos == 7'h70 |-> coil_x_setpoint == -11'sh28B && coil_y_setpoint == 11'sh28B)
		else $error("wrong setpoints at position 112");

	AST_TABLE_127: assert property (
		st_r.pos == 7'h7F |-> coil_x_setpoint == -11'sh023 && coil_y_setpoint == 11'sh3DC)
		else $error("wrong setpoints at position 127");

	AST_COIL_TRACK: assert property (
		$stable(st_r.pos) |-> $stable(coil_x_setpoint) && $stable(coil_y_setpoint))
		else $error("setpoints moved without a position change");

	// register side: armed mode and the position read back
	AST_MODE_WRITE: assert property (
		st_r.wr_pend && st_r.wr_addr == ADDR_CTRL
		|=> st_r.mode_set == $past(hwdata[CTRL_MODE_LSB +: MODE_W]))
		else $error("written step mode not armed");

	AST_POS_READ: assert property (
		bus_take && !hwrite && haddr[11:0] == ADDR_STATUS
		|=> hrdata[POS_W-1:0] == st_r.pos)
		else $error("status read not the current position");
endmodule // mst_translator

// file: testbench/mst_mcu_model.sv
// controller model driving the step and direction pins
`timescale 1ns/1ps
module mst_mcu_model
(
	input  wire logic clk,
	output logic      step_pulse_in,
	output logic      dir_in
);
	// pins idle low from time zero
	initial
	begin
		step_pulse_in = 1'b0;
		dir_in        = 1'b0;
	end

	// six edges per level, longer than sync plus edge delay
	task automatic level(input logic v);
		@(posedge clk) step_pulse_in <= v;
		repeat (6) @(posedge clk);
	endtask

	// direction moves only between pulses, so each edge sees it settled
	task automatic set_dir(input logic v);
		@(posedge clk) dir_in <= v;
		repeat (4) @(posedge clk);
	endtask

	// a whole pulse holds one active edge whatever the polarity
	task automatic pulse();
		level(1'b1);
		level(1'b0);
	endtask
endmodule // mst_mcu_model

// file: testbench/testbench.sv
// self-checking bench for the micro-step translator
`timescale 1ns/1ps
module testbench;
	import mst_pkg::*;

	logic                     clk;
	logic                     rst_n;
	logic                     step_pulse_in;
	logic                     dir_in;
	logic                     pwm_period_start;
	logic signed [COIL_W-1:0] coil_x;
	logic signed [COIL_W-1:0] coil_y;
	logic [CUR_W-1:0]         peak;
	logic                     hsel;
	logic [31:0]              haddr;
	logic [1:0]               htrans;
	logic                     hwrite;
	logic [2:0]               hsize;
	logic [31:0]              hwdata;
	logic                     hreadyout;
	logic                     hresp;
	logic [31:0]              hrdata;
	logic [31:0]              rd;
	logic [6:0]               e;
	int                       failures;
	int                       n_checks;

	mst_translator u_dut
	(
		.clk               (clk),
		.rst_n             (rst_n),
		.step_pulse_in     (step_pulse_in),
		.dir_in            (dir_in),
		.pwm_period_start  (pwm_period_start),
		.coil_x_setpoint   (coil_x),
		.coil_y_setpoint   (coil_y),
		.coil_peak_current (peak),
		.hsel              (hsel),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (hsize),
		.hwdata            (hwdata),
		.hready            (hreadyout),
		.hreadyout         (hreadyout),
		.hresp             (hresp),
		.hrdata            (hrdata)
	);

	mst_mcu_model u_mcu
	(
		.clk           (clk),
		.step_pulse_in (step_pulse_in),
		.dir_in        (dir_in)
	);

	// 25 MHz clock and time-zero values
	always #20 clk = ~clk;
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		pwm_period_start = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		failures = 0;
		n_checks = 0;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one single transfer; no cycle count assumed, ready decides
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic rd_pos(input logic [6:0] p);
		ahb(1'b0, ADDR_STATUS, 32'h0);
		chk("position", {25'h0, p}, {25'h0, rd[6:0]});
	endtask

	task automatic coil(input logic [10:0] x, input logic [10:0] y);
		chk("coil x", {21'h0, x}, {21'h0, coil_x});
		chk("coil y", {21'h0, y}, {21'h0, coil_y});
	endtask

	task automatic ctrl(input logic [4:0] v);
		ahb(1'b1, ADDR_CTRL, {27'h0, v});
	endtask

	task automatic step(input logic [6:0] p);
		u_mcu.pulse();
		rd_pos(p);
	endtask

	task automatic summarize();
		$display("errors=%0d checks=%0d", failures, n_checks);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// about 390 cycles of traffic; nearly forty times that means a hang
	initial
	begin
		repeat (15000) @(posedge clk);
		failures++;
		$display("[FAIL] run expected done seen timeout");
		summarize();
	end

	// main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		ahb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		ahb(1'b0, ADDR_CUR, 32'h0);
		chk("cur reset", 32'h0, rd);
		ahb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
		ahb(1'b0, ADDR_STATUS, 32'h0);
		chk("status read-only", 32'h0, rd);
		ahb(1'b0, ADDR_COIL, 32'h0);
		chk("coil reset", 32'h03E80000, rd & 32'h07FF07FF);
		ahb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 32'h0, rd);
		// wrap down from zero, then back up
		step(7'h7F);
		coil(-11'sh023, 11'sh3DC);
		u_mcu.set_dir(1'b1);
		step(7'h00);
		// all four pin and control-bit combinations
		e = 7'h00;
		for (int i = 0; i < 4; i++)
		begin
			u_mcu.set_dir(i[0]);
			ctrl({1'b0, i[1], 3'h0});
			e = (i[0] ^ i[1]) ? e + 7'h01 : e - 7'h01;
			step(e);
		end
		// full step from a shared point; mode waits for the edge
		ctrl(5'h05);
		ahb(1'b0, ADDR_STATUS, 32'h0);
		chk("mode before step", 32'h0, rd & 32'h0000077F);
		step(7'h20);
		step(7'h40);
		step(7'h60);
		coil(-11'sh3E8, 11'sh000);
		ctrl(5'h04);
		step(7'h70);
		coil(-11'sh28B, 11'sh28B);
		// controller coarsens off grid on purpose, then refines
		ctrl(5'h00);
		step(7'h71);
		ctrl(5'h03);
		step(7'h79);
		ctrl(5'h02);
		step(7'h7C);
		chk("applied mode", 32'h2, {29'h0, rd[10:8]});
		// falling polarity: the rising edge must not step
		ctrl(5'h12);
		u_mcu.level(1'b1);
		rd_pos(7'h7C);
		u_mcu.level(1'b0);
		rd_pos(7'h00);
		// peak code waits for the period start
		ahb(1'b1, ADDR_CUR, 32'h0000001B);
		repeat (4) @(posedge clk);
		chk("peak before period", 32'h0, {27'h0, peak});
		pwm_period_start <= 1'b1;
		@(posedge clk);
		pwm_period_start <= 1'b0;
		@(posedge clk);
		chk("peak applied", 32'h1B, {27'h0, peak});
		ahb(1'b0, ADDR_STATUS, 32'h0);
		chk("status peak", 32'h001B0000, rd & 32'h001F0000);
		// remaining full-step codes and 1/16 mode, rising edge again
		ctrl(5'h07);
		step(7'h20);
		ctrl(5'h01);
		step(7'h22);
		ctrl(5'h06);
		step(7'h42);
		summarize();
	end
endmodule // testbench
